// ---- rtl/compact_timer_pkg.sv ----
// Constants and types of the compact 10-bit timer with PWM.
// Assumes a 32-bit AHB-Lite slave with byte-wide registers in the low lanes.
package compact_timer_pkg;

    localparam int CNT_W = 10;
    localparam int P_W = 3;
    localparam int AW = 8;

    // Register byte addresses
    localparam logic [AW-1:0] OFF_CTRL0 = 8'h00;
    localparam logic [AW-1:0] OFF_CTRL1 = 8'h04;
    localparam logic [AW-1:0] OFF_CNT_LO = 8'h08;
    localparam logic [AW-1:0] OFF_CNT_HI = 8'h0c;
    localparam logic [AW-1:0] OFF_CMPA_LO = 8'h10;
    localparam logic [AW-1:0] OFF_CMPA_HI = 8'h14;
    localparam logic [AW-1:0] OFF_FLAGS = 8'h18;

    // Field positions
    localparam int CTRL0_P_LSB = 0;
    localparam int CTRL0_ON_BIT = 3;
    localparam int FLAG_A_BIT = 0;
    localparam int FLAG_P_BIT = 1;
    localparam int P_SHIFT = CNT_W - P_W;

    // Reset values
    localparam logic [7:0] RST_CTRL0 = 8'h00;
    localparam logic [7:0] RST_CTRL1 = 8'h00;
    localparam logic [CNT_W-1:0] RST_CMPA = 10'h000;
    localparam logic [CNT_W-1:0] RST_CNT = 10'h000;

    // Count that stands for a zero compare value: a full wrap
    localparam logic [CNT_W:0] FULL_COUNT = 11'h400;

    // Mode and pin action codes
    localparam logic [1:0] MODE_CMP = 2'b00;
    localparam logic [1:0] MODE_PWM = 2'b10;
    localparam logic [1:0] MODE_TIMER = 2'b11;
    localparam logic [1:0] ACT_NONE = 2'b00;
    localparam logic [1:0] ACT_LOW = 2'b01;
    localparam logic [1:0] ACT_HIGH = 2'b10;
    localparam logic [1:0] ACT_TOGGLE = 2'b11;
    localparam logic [1:0] ACT_ACTIVE = 2'b01;
    localparam logic [1:0] ACT_WAVE = 2'b10;

    // Bit layout equals the second control register
    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] action;
        logic initLevel;
        logic invert;
        logic roleSwap;
        logic clearSel;
    } ctrl_s;

    typedef struct packed {
        logic pin;
        logic pinEnable;
        logic irqMatchA;
        logic irqMatchP;
    } timer_out_s;

    typedef struct packed {
        ctrl_s ctrl;
        logic counterOn;
        logic [P_W-1:0] compareP;
        logic [CNT_W-1:0] compareA;
        logic [CNT_W-1:0] counter;
        logic flagA;
        logic flagP;
        logic pinLevel;
        logic pinOut;
        logic dphWrite;
        logic [AW-1:0] dphAddr;
        logic [31:0] rdata;
    } state_s;

    localparam state_s STATE_RST = '{
        ctrl: ctrl_s'(RST_CTRL1),
        counterOn: RST_CTRL0[CTRL0_ON_BIT],
        compareP: RST_CTRL0[CTRL0_P_LSB +: P_W],
        compareA: RST_CMPA,
        counter: RST_CNT,
        default: '0
    };

endpackage : compact_timer_pkg

// ---- rtl/compact_timer.sv ----
// Compact 10-bit timer: compare match, PWM and plain timer modes.
// Assumes timerTick is a one-cycle enable from a clock selector on ref_clk,
// and counterPause is a level from logic on the same clock.
`timescale 1ns/1ps

module compact_timer (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic timerTick,
    input wire logic counterPause,
    output compact_timer_pkg::timer_out_s timerOut
);
    import compact_timer_pkg::*;

    state_s stateReg;
    state_s stateNext;
    logic onRise;
    logic countEn;
    logic matchAEv;
    logic matchPEv;
    logic [CNT_W:0] nextCnt;
    logic [CNT_W:0] pTarget;
    logic [CNT_W:0] period;
    logic aHit;
    logic pHit;
    logic clearCnt;
    logic isPwm;
    logic isCmp;

    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    // P compares with the top three bits, so zero means a full wrap
    function automatic logic [CNT_W:0] pTargetOf(input logic [P_W-1:0] p);
        if (p == '0) begin
            return FULL_COUNT;
        end
        return {1'b0, p, {P_SHIFT{1'b0}}};
    endfunction : pTargetOf

    // Pin level follows the whole state, so it stays consistent when frozen
    function automatic logic pinDrive(input state_s st);
        logic [CNT_W:0] duty;
        logic active;
        logic lvl;
        duty = st.ctrl.roleSwap ? pTargetOf(st.compareP) : {1'b0, st.compareA};
        active = {1'b0, st.counter} < duty;
        if (st.ctrl.mode == MODE_PWM) begin
            unique case (st.ctrl.action)
                ACT_ACTIVE: active = 1'b1;
                ACT_WAVE: active = active;
                default: active = 1'b0;
            endcase
            lvl = active ? st.ctrl.initLevel : ~st.ctrl.initLevel;
        end else begin
            lvl = st.pinLevel;
        end
        return lvl ^ st.ctrl.invert;
    endfunction : pinDrive

    function automatic logic [31:0] readMux(input state_s st, input logic [AW-1:0] a);
        logic [31:0] d;
        d = '0;
        unique case (a)
            OFF_CTRL0: begin
                d[CTRL0_ON_BIT] = st.counterOn;
                d[CTRL0_P_LSB +: P_W] = st.compareP;
            end
            OFF_CTRL1: d[7:0] = st.ctrl;
            OFF_CNT_LO: d[7:0] = st.counter[7:0];
            OFF_CNT_HI: d[1:0] = st.counter[9:8];
            OFF_CMPA_LO: d[7:0] = st.compareA[7:0];
            OFF_CMPA_HI: d[1:0] = st.compareA[9:8];
            OFF_FLAGS: begin
                d[FLAG_A_BIT] = st.flagA;
                d[FLAG_P_BIT] = st.flagP;
            end
            default: d = '0;
        endcase
        return d;
    endfunction : readMux

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    assign isPwm = stateReg.ctrl.mode == MODE_PWM;
    assign isCmp = !isPwm && stateReg.ctrl.mode != MODE_TIMER;

    always_comb begin
        stateNext = stateReg;
        matchAEv = 1'b0;
        matchPEv = 1'b0;
        clearCnt = 1'b0;
        period = FULL_COUNT;

        // Write data phase; only the low byte lane carries data
        if (stateReg.dphWrite) begin
            case (stateReg.dphAddr)
                OFF_CTRL0: begin
                    stateNext.counterOn = hwdata[CTRL0_ON_BIT];
                    stateNext.compareP = hwdata[CTRL0_P_LSB +: P_W];
                end
                OFF_CTRL1: stateNext.ctrl = ctrl_s'(hwdata[7:0]);
                OFF_CMPA_LO: stateNext.compareA[7:0] = hwdata[7:0];
                OFF_CMPA_HI: stateNext.compareA[9:8] = hwdata[1:0];
                OFF_FLAGS: begin
                    if (hwdata[FLAG_A_BIT]) begin
                        stateNext.flagA = 1'b0;
                    end
                    if (hwdata[FLAG_P_BIT]) begin
                        stateNext.flagP = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        onRise = stateNext.counterOn && !stateReg.counterOn;
        countEn = stateReg.counterOn && !counterPause && timerTick;
        nextCnt = {1'b0, stateReg.counter} + 11'd1;
        pTarget = pTargetOf(stateReg.compareP);
        // A zero compare A never matches; the count just wraps
        aHit = stateReg.compareA != '0 && nextCnt == {1'b0, stateReg.compareA};
        pHit = nextCnt == pTarget;

        if (isPwm) begin
            // Clear-source select plays no part here
            if (stateReg.ctrl.roleSwap) begin
                period = aHit ? nextCnt : FULL_COUNT;
            end else begin
                period = pTarget;
            end
            clearCnt = nextCnt == period || nextCnt == FULL_COUNT;
        end else if (stateReg.ctrl.clearSel) begin
            clearCnt = aHit || nextCnt == FULL_COUNT;
        end else begin
            clearCnt = pHit;
        end

        if (onRise) begin
            stateNext.counter = '0;
            if (stateNext.ctrl.mode != MODE_TIMER) begin
                stateNext.pinLevel = stateNext.ctrl.initLevel;
            end
        end else if (countEn) begin
            matchAEv = aHit;
            matchPEv = pHit && (isPwm || !stateReg.ctrl.clearSel);
            stateNext.counter = clearCnt ? '0 : nextCnt[CNT_W-1:0];
            if (isCmp && aHit) begin
                unique case (stateReg.ctrl.action)
                    ACT_LOW: stateNext.pinLevel = 1'b0;
                    ACT_HIGH: stateNext.pinLevel = 1'b1;
                    ACT_TOGGLE: stateNext.pinLevel = ~stateReg.pinLevel;
                    ACT_NONE: stateNext.pinLevel = stateReg.pinLevel;
                endcase
            end
        end

        // A match in the clearing cycle still sets the flag
        stateNext.flagA = stateNext.flagA | matchAEv;
        stateNext.flagP = stateNext.flagP | matchPEv;
        stateNext.pinOut = pinDrive(stateNext);

        // Address phase; read data is latched for the data phase
        stateNext.dphWrite = hsel && htrans[1] && hwrite && hready;
        stateNext.dphAddr = haddr[AW-1:0];
        stateNext.rdata = readMux(stateNext, haddr[AW-1:0]);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stateReg <= STATE_RST;
        end else if (ce) begin
            stateReg <= stateNext;
        end
    end

    // -------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------
    // Wait states while frozen keep the bus from losing a transfer
    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign hrdata = stateReg.rdata;
    assign timerOut.pin = stateReg.pinOut;
    assign timerOut.pinEnable = stateReg.ctrl.mode != MODE_TIMER;
    assign timerOut.irqMatchA = stateReg.flagA;
    assign timerOut.irqMatchP = stateReg.flagP;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence riseSeq;
        ce && onRise;
    endsequence

    sequence pClearSeq;
        ce && countEn && !onRise && !isPwm && !stateReg.ctrl.clearSel && pHit;
    endsequence

    p_clear_a: assert property (pClearSeq |=> stateReg.counter == '0 && stateReg.flagP)
        else $error("P match did not clear counter");
    p_range_a: assert property (!isPwm && !stateReg.ctrl.clearSel && stateReg.compareP != '0
            |-> {1'b0, stateReg.counter} < pTarget)
        else $error("counter passed P target");
    no_pflag_a: assert property (ce && !isPwm && stateReg.ctrl.clearSel |=> !$rose(stateReg.flagP))
        else $error("P flag set with clear-source high");
    zero_a_a: assert property (ce && stateReg.ctrl.clearSel && stateReg.compareA == '0
            |=> !$rose(stateReg.flagA))
        else $error("A flag set with zero compare A");
    pin_hold_a: assert property (ce && isCmp && !onRise && !(countEn && aHit)
            |=> $stable(stateReg.pinLevel))
        else $error("pin moved without A match");
    pin_toggle_a: assert property (ce && isCmp && !onRise && countEn && aHit
            && stateReg.ctrl.action == ACT_TOGGLE
            |=> stateReg.pinLevel != $past(stateReg.pinLevel))
        else $error("toggle action did not toggle");
    full_duty_a: assert property (isPwm && stateReg.ctrl.action == ACT_WAVE
            && !stateReg.ctrl.roleSwap && {1'b0, stateReg.compareA} >= pTarget
            |-> timerOut.pin == (stateReg.ctrl.initLevel ^ stateReg.ctrl.invert))
        else $error("full duty not held active");
    pwm_force_a: assert property (isPwm && stateReg.ctrl.action == ACT_NONE
            |-> timerOut.pin == (~stateReg.ctrl.initLevel ^ stateReg.ctrl.invert))
        else $error("forced inactive level wrong");
    on_rise_a: assert property (riseSeq |=> (stateReg.counter == '0)
            and (ce [*2] |-> stateReg.counter <= 10'h002))
        else $error("counter not zeroed on enable");
    init_level_a: assert property (riseSeq ##0 stateNext.ctrl.mode == MODE_CMP
            |=> stateReg.pinLevel == stateReg.ctrl.initLevel)
        else $error("pin not at initial level");
    flag_keep_a: assert property (ce && stateReg.flagA
            && !(stateReg.dphWrite && stateReg.dphAddr == OFF_FLAGS)
            |=> stateReg.flagA)
        else $error("A flag lost without clear");
    flag_p_keep_a: assert property (ce && stateReg.flagP
            && !(stateReg.dphWrite && stateReg.dphAddr == OFF_FLAGS)
            |=> stateReg.flagP)
        else $error("P flag lost without clear");

    // -------------------------------------------------------------
    // Counting, clearing and waveform checks
    // -------------------------------------------------------------
    // An accepted tick; a counter-on rise overrides it
    sequence tickSeq;
        ce && countEn && !onRise;
    endsequence

    sequence aMatchSeq;
        tickSeq ##0 aHit;
    endsequence

    // The PWM period comes from P unless the roles are swapped
    sequence pwmPeriodSeq;
        tickSeq ##0 isPwm && (stateReg.ctrl.roleSwap ? aHit : pHit);
    endsequence

    cnt_step_a: assert property (tickSeq ##0 !clearCnt
            |=> stateReg.counter == $past(stateReg.counter) + 10'd1)
        else $error("counter did not step by one");
    cnt_wrap_a: assert property (tickSeq ##0 stateReg.counter == 10'h3ff
            |=> stateReg.counter == '0)
        else $error("counter did not wrap after its maximum");
    cnt_hold_a: assert property (ce && !onRise && !countEn |=> $stable(stateReg.counter))
        else $error("counter moved while stopped");
    a_clear_a: assert property (aMatchSeq ##0 !isPwm && stateReg.ctrl.clearSel
            |=> stateReg.counter == '0)
        else $error("A match did not clear counter");
    a_flag_a: assert property (aMatchSeq |=> stateReg.flagA)
        else $error("A match did not set A flag");
    pwm_pflag_a: assert property (tickSeq ##0 isPwm && pHit |=> stateReg.flagP)
        else $error("PWM P match did not set P flag");
    pwm_period_a: assert property (pwmPeriodSeq |=> stateReg.counter == '0)
        else $error("PWM period did not clear counter");
    // An A match must not end a P period, whatever the clear-source select says
    pwm_sel_a: assert property (tickSeq ##0 isPwm && !stateReg.ctrl.roleSwap
            && stateReg.ctrl.clearSel && aHit && !pHit
            |=> stateReg.counter != '0)
        else $error("clear-source select acted in PWM mode");
    pin_high_a: assert property (aMatchSeq ##0 isCmp && stateReg.ctrl.action == ACT_HIGH
            |=> stateReg.pinLevel)
        else $error("high action did not raise pin");
    pin_low_a: assert property (aMatchSeq ##0 isCmp && stateReg.ctrl.action == ACT_LOW
            |=> !stateReg.pinLevel)
        else $error("low action did not lower pin");
    timer_pin_a: assert property (ce && stateReg.ctrl.mode == MODE_TIMER && !onRise
            |=> $stable(stateReg.pinLevel))
        else $error("pin level moved in timer mode");
    pwm_duty_a: assert property (isPwm && stateReg.ctrl.action == ACT_WAVE
            && !stateReg.ctrl.roleSwap && stateReg.counter >= stateReg.compareA
            |-> timerOut.pin == (~stateReg.ctrl.initLevel ^ stateReg.ctrl.invert))
        else $error("PWM pin active past duty");
    pwm_swap_duty_a: assert property (isPwm && stateReg.ctrl.action == ACT_WAVE
            && stateReg.ctrl.roleSwap && {1'b0, stateReg.counter} < pTarget
            |-> timerOut.pin == (stateReg.ctrl.initLevel ^ stateReg.ctrl.invert))
        else $error("swapped PWM pin inactive in duty");
    pwm_active_a: assert property (isPwm && stateReg.ctrl.action == ACT_ACTIVE
            |-> timerOut.pin == (stateReg.ctrl.initLevel ^ stateReg.ctrl.invert))
        else $error("forced active level wrong");

endmodule : compact_timer

// ---- testbench/compact_timer_test.sv ----
// Self-checking bench for the compact timer: AHB-Lite register tasks and
// timer tick bursts. Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
module compact_timer_test;
    import compact_timer_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic timerTick = 1'b0, counterPause = 1'b0, hreadyout, hresp;
    timer_out_s timerOut;
    int fails = 0, n_checks = 0;

    compact_timer dut_u (.ref_clk(ref_clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timerTick(timerTick),
        .counterPause(counterPause), .timerOut(timerOut));

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    // ----------------------------------------------------------------
    // Bus and check tasks
    // ----------------------------------------------------------------
    task print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    task check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Bounded wait for hready, sampled at each rising edge
    task wait_ready();
        int i;
        for (i = 0; i < 50; i++) begin
            @(posedge ref_clk);
            if (hreadyout === 1'b1) break;
        end
        if (i == 50) begin
            fails++;
            $display("mismatch at %0t: bus never ready", $time);
            print_verdict();
        end
    endtask : wait_ready

    task xfer(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : xfer

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        xfer(a, 1'b1, d, unused);
    endtask : wr

    task chk_reg(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        xfer(a, 1'b0, 32'h0, d);
        check(d, exp);
    endtask : chk_reg

    task chk_cnt(input logic [9:0] c);
        chk_reg(OFF_CNT_LO, {24'h0, c[7:0]});
        chk_reg(OFF_CNT_HI, {30'h0, c[9:8]});
    endtask : chk_cnt

    // One tick per cycle, then one idle edge so the last update has landed
    task tick(input int n);
        timerTick <= 1'b1;
        repeat (n) @(posedge ref_clk);
        timerTick <= 1'b0;
        @(posedge ref_clk);
    endtask : tick

    // Counter off, load values, clear flags, counter on
    task setup(input logic [7:0] c1, input logic [2:0] p, input logic [9:0] a);
        wr(OFF_CTRL0, 32'h0);
        wr(OFF_CMPA_LO, {24'h0, a[7:0]});
        wr(OFF_CMPA_HI, {30'h0, a[9:8]});
        wr(OFF_CTRL1, {24'h0, c1});
        wr(OFF_FLAGS, 32'h3);
        wr(OFF_CTRL0, {28'h0, 1'b1, p});
    endtask : setup

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        check({31'h0, timerOut.pinEnable}, 32'h1);
        chk_cnt(10'h0);
        chk_reg(OFF_CMPA_LO, 32'h0);
        chk_reg(OFF_CMPA_HI, 32'h0);
        chk_reg(OFF_FLAGS, 32'h0);
        wr(OFF_CMPA_HI, 32'hffffffff);
        chk_reg(OFF_CMPA_HI, 32'h3);
        wr(OFF_CNT_LO, 32'h55);
        chk_cnt(10'h0);
        wr(8'h1c, 32'hff);
        chk_reg(8'h1c, 32'h0);
        // Compare mode, clear on A, toggle, A above the P step
        setup(8'h31, 3'd1, 10'd300);
        tick(300);
        chk_cnt(10'h0);
        chk_reg(OFF_FLAGS, 32'h1);
        check({31'h0, timerOut.pin}, 32'h1);
        tick(300);
        check({31'h0, timerOut.pin}, 32'h0);
        tick(300);
        tick(2);
        wr(OFF_CTRL0, 32'h1);
        tick(5);
        chk_cnt(10'd2);
        wr(OFF_CTRL0, 32'h9);
        chk_cnt(10'h0);
        check({31'h0, timerOut.pin}, 32'h0);
        // Undefined mode 01 runs as compare mode: drive high on A
        setup(8'h61, 3'd0, 10'd3);
        tick(3);
        chk_cnt(10'h0);
        check({31'h0, timerOut.pin}, 32'h1);
        // Drive low on A from an inverted high start
        setup(8'h1d, 3'd0, 10'd3);
        check({31'h0, timerOut.pin}, 32'h0);
        tick(3);
        check({31'h0, timerOut.pin}, 32'h1);
        // Clear on P: both flags, pin moves only on A
        setup(8'h30, 3'd2, 10'd5);
        tick(5);
        check({31'h0, timerOut.pin}, 32'h1);
        tick(251);
        chk_cnt(10'h0);
        chk_reg(OFF_FLAGS, 32'h3);
        check({31'h0, timerOut.pin}, 32'h1);
        wr(OFF_FLAGS, 32'h1);
        chk_reg(OFF_FLAGS, 32'h2);
        check({30'h0, timerOut.irqMatchA, timerOut.irqMatchP}, 32'h1);
        // Clear on A with A zero: full wrap, no A flag; pause and ce hold
        setup(8'h01, 3'd0, 10'd0);
        tick(1023);
        chk_cnt(10'h3ff);
        counterPause <= 1'b1;
        tick(5);
        counterPause <= 1'b0;
        ce <= 1'b0;
        tick(3);
        check({31'h0, hreadyout}, 32'h0);
        ce <= 1'b1;
        chk_cnt(10'h3ff);
        tick(1);
        chk_cnt(10'h0);
        chk_reg(OFF_FLAGS, 32'h0);
        // Clear on P with P zero: overflow clears
        setup(8'h00, 3'd0, 10'd0);
        tick(1024);
        chk_cnt(10'h0);
        // Timer mode: same clearing and flags, pin released
        setup(8'hf0, 3'd1, 10'd5);
        check({31'h0, timerOut.pinEnable}, 32'h0);
        tick(128);
        chk_cnt(10'h0);
        chk_reg(OFF_FLAGS, 32'h3);
        // PWM, P period 128, A duty 32, clear select ignored
        setup(8'ha9, 3'd1, 10'd32);
        tick(10);
        check({31'h0, timerOut.pin}, 32'h1);
        tick(30);
        check({31'h0, timerOut.pin}, 32'h0);
        chk_cnt(10'd40);
        tick(88);
        chk_cnt(10'h0);
        chk_reg(OFF_FLAGS, 32'h3);
        // Forced active level keeps counting; pin stays at the initial level
        setup(8'h98, 3'd1, 10'd32);
        tick(60);
        check({31'h0, timerOut.pin}, 32'h1);
        chk_cnt(10'd60);
        // Forced inactive level, the unused action code, and the inverted wave in its active part
        setup(8'h88, 3'd1, 10'd32);
        tick(60);
        check({31'h0, timerOut.pin}, 32'h0);
        chk_cnt(10'd60);
        setup(8'hb8, 3'd1, 10'd32);
        tick(10);
        check({31'h0, timerOut.pin}, 32'h0);
        setup(8'hac, 3'd1, 10'd32);
        tick(10);
        check({31'h0, timerOut.pin}, 32'h0);
        // Duty above period holds active
        setup(8'ha8, 3'd1, 10'd200);
        tick(120);
        check({31'h0, timerOut.pin}, 32'h1);
        // Swapped roles: A period 200, P duty 128
        setup(8'haa, 3'd1, 10'd200);
        tick(100);
        check({31'h0, timerOut.pin}, 32'h1);
        tick(50);
        check({31'h0, timerOut.pin}, 32'h0);
        tick(50);
        chk_cnt(10'h0);
        chk_reg(OFF_CTRL1, 32'haa);
        chk_reg(OFF_CTRL0, 32'h9);
        tick(3);
        // Mid-run reset restores the count, compare A low byte and both control registers
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk_cnt(10'h0);
        chk_reg(OFF_CMPA_LO, 32'h0);
        chk_reg(OFF_CTRL1, 32'h0);
        chk_reg(OFF_CTRL0, 32'h0);
        check({31'h0, timerOut.pinEnable}, 32'h1);
        check({31'h0, hresp}, 32'h0);
        print_verdict();
    end
endmodule : compact_timer_test
